//--- hdl/spm_port.sv
// SPI mode of a synchronous serial port: master or slave, MSb first,
// full duplex, buffered receive and unbuffered transmit.
// Assumes control bits and buffer strobes come from logic on REF_CLK and
// that pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_port (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PORT_ENABLE_BIT,
  input wire logic [3:0] MODE_SEL,
  input wire logic CLK_IDLE_HIGH,
  input wire logic CLK_EDGE_SEL,
  input wire logic SAMPLE_END,
  input wire logic [7:0] PORT_ADDRESS_REG,
  input wire logic TIMER_TICK,
  input wire logic BUF_WR,
  input wire logic [7:0] BUF_WR_DATA,
  input wire logic BUF_RD,
  input wire logic COLLISION_CLR,
  input wire logic INTERRUPT_CLR,
  input wire logic OVERRUN_CLR,
  output logic [7:0] BUF_RD_DATA,
  output logic BUFFER_FULL_FLAG,
  output logic PORT_INTERRUPT_FLAG,
  output logic WRITE_COLLISION_FLAG,
  output logic RX_OVERRUN_FLAG,
  output logic BUSY,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic SS_N
);
  // ----------------------------------------------------------------
  // Edge decisions, shared by the master and slave sequencers
  // ----------------------------------------------------------------
  // Index counts serial clock edges: even leading, odd trailing, 16 end
  function automatic logic samp_at(input logic [4:0] idx, input logic cke,
                                   input logic smp);
    if (smp) samp_at = cke ? idx[0] : (!idx[0] && idx != 5'h00);
    else samp_at = (idx[0] == !cke) && (idx != `SPM_LAST_TICK);
  endfunction

  function automatic logic drive_at(input logic [4:0] idx, input logic cke);
    drive_at = (idx != `SPM_LAST_TICK) && (cke ? idx[0] : !idx[0]);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s1, sck_s2, sck_s3;
  logic sdi_s1, sdi_s2;
  logic ss_s1, ss_s2;

  // Two flops per pin; third sck flop only serves edge detection
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
      {ss_s1, ss_s2} <= 2'h3;
    end else begin
      {sck_s1, sck_s2, sck_s3} <= {SCK_IN, sck_s1, sck_s2};
      {sdi_s1, sdi_s2} <= {SDI, sdi_s1};
      {ss_s1, ss_s2} <= {SS_N, ss_s1};
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  spm_pkg::spm_state_t state, next_state;
  logic [4:0] edge_idx;
  logic [2:0] bit_cnt;
  logic [9:0] div_cnt;
  logic [7:0] port_shift_reg;
  logic sdo_q, sck_q, done_q;

  wire en = PORT_ENABLE_BIT;
  wire slave = (MODE_SEL == `SPM_MODE_SLV_SEL) || (MODE_SEL == `SPM_MODE_SLV_FREE);
  wire master = !slave;
  wire sel_ctl = (MODE_SEL == `SPM_MODE_SLV_SEL);
  wire deselect = sel_ctl && ss_s2;
  wire slave_on = en && slave && !deselect;
  wire timer_mode = (MODE_SEL == `SPM_MODE_TIMER);
  // Half-period reload for the selected master rate
  wire [9:0] reload = (MODE_SEL == `SPM_MODE_DIV16) ? `SPM_RELOAD_DIV16 :
                      (MODE_SEL == `SPM_MODE_DIV64) ? `SPM_RELOAD_DIV64 :
                      (MODE_SEL == `SPM_MODE_BRG) ? {1'b0, PORT_ADDRESS_REG, 1'b1} :
                      `SPM_RELOAD_DIV4;

  // ----------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------
  wire running = (state == spm_pkg::SPM_RUN);
  wire div_tick = running && (timer_mode ? TIMER_TICK : (div_cnt == 10'h000));
  wire slv_edge = slave_on && (sck_s2 != sck_s3);
  wire ev = master ? div_tick : slv_edge;
  wire samp = ev && samp_at(edge_idx, CLK_EDGE_SEL, SAMPLE_END && master);
  wire drv = ev && drive_at(edge_idx, CLK_EDGE_SEL);
  wire m_done = div_tick && (edge_idx == `SPM_LAST_TICK);
  wire s_done = slave && samp && (bit_cnt == `SPM_LAST_BIT);
  wire [4:0] idx_inc = slave ? {1'b0, edge_idx[3:0] + 4'h1} : edge_idx + 5'h01;

  // Mid-byte in either role; the push cycle also counts
  assign BUSY = done_q || (master ? running : (bit_cnt != 3'h0 || edge_idx != 5'h00));

  // ----------------------------------------------------------------
  // Software access to the data buffer
  // ----------------------------------------------------------------
  wire wr_ok = BUF_WR && !BUSY && !WRITE_COLLISION_FLAG;
  wire wr_clash = BUF_WR && BUSY;
  wire rx_in_ready, rx_out_valid;
  wire [7:0] rx_out_data;
  wire take = rx_out_valid && !BUFFER_FULL_FLAG && !wr_ok;
  wire lost = done_q && !rx_in_ready;

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  // A write in master mode starts the byte; the end tick closes it
  always_comb begin
    next_state = state;
    case (state)
      spm_pkg::SPM_IDLE: if (en && master && wr_ok) next_state = spm_pkg::SPM_RUN;
      spm_pkg::SPM_RUN: if (!en || !master || m_done) next_state = spm_pkg::SPM_IDLE;
      default: next_state = spm_pkg::SPM_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) state <= spm_pkg::SPM_IDLE;
    else state <= next_state;
  end

  // Half-period divider; first edge comes one full half period after start
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) div_cnt <= 10'h000;
    else if (!running || div_cnt == 10'h000) div_cnt <= reload;
    else div_cnt <= div_cnt - 10'h001;
  end

  // ----------------------------------------------------------------
  // Edge and bit counters
  // ----------------------------------------------------------------
  // Disable, select release and byte end all return to bit zero
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      edge_idx <= 5'h00;
      bit_cnt <= 3'h0;
    end else if (!en || deselect || m_done || !(running || slave)) begin
      edge_idx <= 5'h00;
      bit_cnt <= 3'h0;
    end else if (ev) begin
      edge_idx <= idx_inc;
      if (samp) bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Shift register and data out
  // ----------------------------------------------------------------
  // Shifts MSb out and SDI into the LSb; loads only from a buffer write
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) port_shift_reg <= `SPM_BYTE_RESET;
    else if (wr_ok) port_shift_reg <= BUF_WR_DATA;
    else if (samp) port_shift_reg <= {port_shift_reg[6:0], sdi_s2};
  end

  // When sample and drive share an edge, the bit after the MSb goes out
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) sdo_q <= 1'b0;
    else if (wr_ok) sdo_q <= BUF_WR_DATA[7];
    else if (drv) sdo_q <= samp ? port_shift_reg[6] : port_shift_reg[7];
  end

  // Serial clock toggles on the sixteen edge ticks, idles otherwise
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) sck_q <= 1'b0;
    else if (!running) sck_q <= CLK_IDLE_HIGH;
    else if (div_tick && edge_idx != `SPM_LAST_TICK) sck_q <= !sck_q;
  end

  // Byte end is pushed one cycle later, after the last sample has landed
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) done_q <= 1'b0;
    else done_q <= (master && m_done) || s_done;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign SCK_OUT = sck_q;
  assign SCK_OE = en && master;
  assign SDO = sdo_q;
  assign SDO_OE = en && (master || slave_on);

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  // Two-entry buffer lets the next byte finish before software reads
  spm_rx_buf #(
    .WIDTH(`SPM_BYTE_WIDTH),
    .DEPTH(`SPM_RX_DEPTH)
  ) u_rx_buf (
    .clk(REF_CLK),
    .rst_n(ARST_N),
    .in_valid(done_q),
    .in_data(port_shift_reg),
    .in_ready(rx_in_ready),
    .out_valid(rx_out_valid),
    .out_ready(take),
    .out_data(rx_out_data)
  );

  // Data buffer: software write wins, else the next received byte
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) BUF_RD_DATA <= `SPM_BYTE_RESET;
    else if (wr_ok) BUF_RD_DATA <= BUF_WR_DATA;
    else if (take) BUF_RD_DATA <= rx_out_data;
  end

  // ----------------------------------------------------------------
  // Status flags; a setting event wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUFFER_FULL_FLAG <= 1'b0;
      PORT_INTERRUPT_FLAG <= 1'b0;
      WRITE_COLLISION_FLAG <= 1'b0;
      RX_OVERRUN_FLAG <= 1'b0;
    end else begin
      BUFFER_FULL_FLAG <= take || (BUFFER_FULL_FLAG && !BUF_RD);
      PORT_INTERRUPT_FLAG <= take || (PORT_INTERRUPT_FLAG && !INTERRUPT_CLR);
      WRITE_COLLISION_FLAG <= wr_clash || (WRITE_COLLISION_FLAG && !COLLISION_CLR);
      RX_OVERRUN_FLAG <= lost || (RX_OVERRUN_FLAG && !OVERRUN_CLR);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  a_released_no_drive: assert property (en && slave && deselect |-> !SDO_OE)
    else $error("Deselected slave drives data out");
  a_release_zero_count: assert property (en && deselect |=> bit_cnt == 3'h0)
    else $error("Select release did not clear bit counter");
  a_clash_sets_flag: assert property (BUF_WR && BUSY |=> WRITE_COLLISION_FLAG)
    else $error("Write while busy did not flag a collision");
  a_clash_blocks_write: assert property (
    WRITE_COLLISION_FLAG && BUF_WR && state == spm_pkg::SPM_IDLE
    |=> state == spm_pkg::SPM_IDLE)
    else $error("Write completed while collision flag set");
  a_read_clears_full: assert property (BUF_RD && !take |=> !BUFFER_FULL_FLAG)
    else $error("Buffer read left full flag set");
  a_byte_sets_flags: assert property (take |=> BUFFER_FULL_FLAG && PORT_INTERRUPT_FLAG
    && BUF_RD_DATA == $past(rx_out_data))
    else $error("Received byte not posted with flags");
  a_write_starts: assert property (
    en && master && wr_ok |=> running && port_shift_reg == $past(BUF_WR_DATA))
    else $error("Master write did not start a transfer");
  a_idle_clock: assert property (en && master && !running |=> SCK_OUT == $past(CLK_IDLE_HIGH))
    else $error("Serial clock not at idle level");
  a_disabled_pins: assert property (!en |-> !SCK_OE && !SDO_OE)
    else $error("Disabled port drives its pins");
  a_slave_clock_in: assert property (en && slave |-> !SCK_OE)
    else $error("Slave drives the serial clock");
  a_byte_complete: assert property (m_done |-> ##1 done_q ##1 rx_out_valid || lost)
    else $error("Master byte end not pushed to receive buffer");

  c_master_byte: cover property (m_done);
  c_slave_byte: cover property (s_done);
  c_collision: cover property (wr_clash);
  c_select_abort: cover property (en && deselect && bit_cnt != 3'h0);
endmodule

//--- hdl/spm_defines.svh
// Constants of the synchronous serial port in SPI mode: mode codes,
// divider reloads, sequence lengths and reset values.
// Assumes it is included by bare name from every file that needs it.
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// ----------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------
`define SPM_MODE_DIV4 4'h0
`define SPM_MODE_DIV16 4'h1
`define SPM_MODE_DIV64 4'h2
`define SPM_MODE_TIMER 4'h3
`define SPM_MODE_SLV_SEL 4'h4
`define SPM_MODE_SLV_FREE 4'h5
`define SPM_MODE_BRG 4'ha

// ----------------------------------------------------------------
// Half-period reloads of the master clock divider (half period - 1)
// ----------------------------------------------------------------
`define SPM_RELOAD_DIV4 10'h001
`define SPM_RELOAD_DIV16 10'h007
`define SPM_RELOAD_DIV64 10'h01f

// ----------------------------------------------------------------
// Sequence and reset values
// ----------------------------------------------------------------
`define SPM_LAST_TICK 5'h10
`define SPM_LAST_BIT 3'h7
`define SPM_BYTE_RESET 8'h00
`define SPM_RX_DEPTH 2
`define SPM_BYTE_WIDTH 8

`endif

//--- hdl/spm_pkg.sv
// Types shared by the serial port files.
// Assumes nothing beyond a SystemVerilog compiler.
package spm_pkg;
  // Master sequencer states
  typedef enum logic {SPM_IDLE, SPM_RUN} spm_state_t;
endpackage

//--- hdl/spm_rx_buf.sv
// Small receive FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_rx_buf #(
  parameter int WIDTH = `SPM_BYTE_WIDTH,
  parameter int DEPTH = `SPM_RX_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  // Storage, written only by an accepted word
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule

//--- hdl/spm_port_dummy_unused.sv
// Holds no logic; the serial port and its receive buffer stand alone.
// Assumes nothing of its surroundings.

//--- testbench/spm_far_end.sv
// Far side of the serial port: holds its own byte, answers the port's
// clock as a slave, or acts as master driving clock and select.
// Assumes clock idle low, data changed on falling and taken on rising edges.
`timescale 1ns/1ps
module spm_far_end (
  input wire logic clk,
  input wire logic sck,
  input wire logic sdo_line,
  output logic sdi_line,
  output logic sck_drv,
  output logic ss_n
);
  logic [7:0] sr = 8'h00;
  logic bit_in = 1'b0;
  logic is_master = 1'b0;

  // Outside a frame in the master role the released data line shows the inverted bit
  assign sdi_line = (is_master && ss_n) ? ~sr[7] : sr[7];
  // Take the incoming bit on the rising edge
  always @(posedge sck) bit_in <= sdo_line;
  // Shift MSb first on the falling edge, new bit at the LSb
  always @(negedge sck) sr <= {sr[6:0], bit_in};

  // Lines idle: clock low, nobody selected
  initial begin
    sck_drv = 1'b0;
    ss_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Master role
  // ----------------------------------------------------------------
  // Frame of n clocks, eight system cycles per half period
  task automatic xfer(input int n);
    is_master = 1'b1;
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    repeat (n) begin
      sck_drv <= 1'b1;
      repeat (8) @(posedge clk);
      sck_drv <= 1'b0;
      repeat (8) @(posedge clk);
    end
    ss_n <= 1'b1;
  endtask
endmodule

//--- testbench/tb_spi_master_slave_port.sv
// Self-checking bench of the serial port: master and slave transfers,
// write collision, master clock rates and receive buffering.
// Assumes the far side model spm_far_end and an idle-low serial clock except in the timer rate check.
`timescale 1ns/1ps
`include "spm_defines.svh"
module tb_spi_master_slave_port;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b0;
  logic [3:0] mode_sel = 4'h1;
  logic sample_end = 1'b0;
  logic [7:0] addr = 8'h02;
  logic timer_tick = 1'b0;
  logic buf_wr = 1'b0;
  logic [7:0] buf_wr_data = 8'h00;
  logic buf_rd = 1'b0;
  logic coll_clr = 1'b0;
  logic irq_clr = 1'b0;
  logic ovr_clr = 1'b0;
  logic clk_idle = 1'b0;
  logic clk_edge = 1'b1;
  logic [7:0] rd_data;
  logic full, irq, coll, busy, sck_out, sck_oe, sdo, sdo_oe, sdi, far_sck, ss_n;
  logic ovr;
  logic sdo_last = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  int n_mismatch = 0;
  int samples_checked = 0;
  wire sck_line = sck_oe ? sck_out : far_sck;
  wire sdo_line = sdo_oe ? sdo : ~sdo_last;

  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;
  // Timer pulse every five cycles
  always @(posedge ref_clk) begin
    tick_cnt <= (tick_cnt == 3'h4) ? 3'h0 : tick_cnt + 3'h1;
    timer_tick <= (tick_cnt == 3'h4);
  end
  // Released data line shows the inverse of its last driven value
  always @(posedge ref_clk) if (sdo_oe) sdo_last <= sdo;

  spm_port i_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .PORT_ENABLE_BIT(en),
    .MODE_SEL(mode_sel), .CLK_IDLE_HIGH(clk_idle), .CLK_EDGE_SEL(clk_edge),
    .SAMPLE_END(sample_end), .PORT_ADDRESS_REG(addr), .TIMER_TICK(timer_tick),
    .BUF_WR(buf_wr), .BUF_WR_DATA(buf_wr_data), .BUF_RD(buf_rd),
    .COLLISION_CLR(coll_clr), .INTERRUPT_CLR(irq_clr), .OVERRUN_CLR(ovr_clr),
    .BUF_RD_DATA(rd_data), .BUFFER_FULL_FLAG(full), .PORT_INTERRUPT_FLAG(irq),
    .WRITE_COLLISION_FLAG(coll), .RX_OVERRUN_FLAG(ovr), .BUSY(busy),
    .SCK_IN(sck_line), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .SS_N(ss_n));

  spm_far_end i_far (.clk(ref_clk), .sck(sck_line), .sdo_line(sdo_line),
    .sdi_line(sdi), .sck_drv(far_sck), .ss_n(ss_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] b);
    @(posedge ref_clk);
    buf_wr <= 1'b1;
    buf_wr_data <= b;
    @(posedge ref_clk);
    buf_wr <= 1'b0;
    #1;
  endtask

  // Pulse 0 reads the buffer, 1 clears collision, 2 interrupt, 3 overrun
  task automatic pulse(input int k);
    @(posedge ref_clk);
    buf_rd <= (k == 0);
    coll_clr <= (k == 1);
    irq_clr <= (k == 2);
    ovr_clr <= (k == 3);
    @(posedge ref_clk);
    {buf_rd, coll_clr, irq_clr, ovr_clr} <= 4'h0;
    #1;
  endtask

  task automatic wait_idle();
    int i = 0;
    while (busy !== 1'b0 && i < 3000) begin
      cyc(1);
      i++;
    end
    check("busy", 10'h000, busy);
  endtask

  task automatic wait_full();
    int i = 0;
    while (full !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
    check("buffer full", 10'h001, full);
  endtask

  // Reconfigure with the port disabled, then enable it again
  task automatic setup(input logic [3:0] m, input logic pol, input logic cke);
    @(posedge ref_clk);
    en <= 1'b0;
    @(posedge ref_clk);
    mode_sel <= m;
    clk_idle <= pol;
    clk_edge <= cke;
    @(posedge ref_clk);
    en <= 1'b1;
    cyc(4);
  endtask

  // Master exchange: port sends tx, far side answers rx
  task automatic mxfer(input logic [7:0] tx, input logic [7:0] rx);
    i_far.sr = rx;
    wr(tx);
    wait_idle();
    wait_full();
    check("far byte", {2'h0, tx}, {2'h0, i_far.sr});
    check("rx byte", {2'h0, rx}, {2'h0, rd_data});
    pulse(0);
    check("full after read", 10'h000, full);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("reset full", 10'h000, full);
    check("reset data", 10'h000, rd_data);
    check("disabled sck oe", 10'h000, sck_oe);
    check("disabled sdo oe", 10'h000, sdo_oe);
  endtask

  task automatic t_master();
    setup(`SPM_MODE_DIV16, 1'b0, 1'b1);
    check("master sck oe", 10'h001, sck_oe);
    mxfer(8'ha5, 8'h3c);
    check("interrupt", 10'h001, irq);
    pulse(2);
    check("interrupt cleared", 10'h000, irq);
    check("sck idle", 10'h000, sck_out);
    @(posedge ref_clk);
    sample_end <= 1'b1;
    mxfer(8'h69, 8'hd2);
    @(posedge ref_clk);
    sample_end <= 1'b0;
  endtask

  task automatic t_collision();
    i_far.sr = 8'h11;
    wr(8'h47);
    wr(8'hb8);
    check("collision", 10'h001, coll);
    wait_idle();
    wait_full();
    check("far kept first", 10'h047, i_far.sr);
    pulse(0);
    wr(8'h22);
    check("write blocked", 10'h000, busy);
    check("write blocked data", 10'h011, rd_data);
    pulse(1);
    check("collision cleared", 10'h000, coll);
    mxfer(8'he1, 8'h1e);
  endtask

  // Three bytes fill data buffer and receive buffer; the fourth is lost
  task automatic t_overrun();
    for (int k = 0; k < 3; k++) begin
      wr(8'h30 + 8'(k));
      wait_idle();
    end
    check("overrun early", 10'h000, ovr);
    wr(8'h33);
    wait_idle();
    check("overrun", 10'h001, ovr);
    check("data after write", 10'h033, rd_data);
    pulse(3);
    check("overrun cleared", 10'h000, ovr);
    repeat (3) pulse(0);
    cyc(2);
    check("drained", 10'h000, full);
  endtask

  task automatic t_rate(input logic [3:0] m, input logic [9:0] half, input logic pol,
                        input logic cke);
    logic s;
    int n;
    setup(m, pol, cke);
    check("idle level", {9'h000, pol}, sck_out);
    wr(8'h00);
    for (int k = 0; k < 2; k++) begin
      s = sck_out;
      n = 0;
      while (sck_out === s && n < 100) begin
        cyc(1);
        n++;
      end
    end
    check("half period", half, 10'(n));
    wait_idle();
    wait_full();
    pulse(0);
  endtask

  task automatic t_slave();
    setup(`SPM_MODE_SLV_SEL, 1'b0, 1'b1);
    check("slave sck oe", 10'h000, sck_oe);
    check("unselected sdo oe", 10'h000, sdo_oe);
    i_far.sr = 8'hc3;
    wr(8'h5a);
    i_far.xfer(8);
    check("far got slave byte", 10'h05a, i_far.sr);
    wait_full();
    check("slave rx", 10'h0c3, rd_data);
    i_far.sr = 8'h96;
    i_far.xfer(8);
    cyc(4);
    check("first byte kept", 10'h0c3, rd_data);
    pulse(0);
    check("full cleared", 10'h000, full);
    wait_full();
    check("second byte", 10'h096, rd_data);
    pulse(0);
    i_far.xfer(3);
    cyc(3);
    check("released sdo oe", 10'h000, sdo_oe);
    i_far.sr = 8'h81;
    i_far.xfer(8);
    wait_full();
    check("resync byte", 10'h081, rd_data);
    setup(`SPM_MODE_SLV_FREE, 1'b0, 1'b1);
    check("free slave sdo oe", 10'h001, sdo_oe);
    @(posedge ref_clk);
    en <= 1'b0;
    cyc(1);
    check("off sdo oe", 10'h000, sdo_oe);
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_master();
    t_collision();
    t_overrun();
    t_rate(`SPM_MODE_DIV4, 10'h002, 1'b0, 1'b1);
    t_rate(`SPM_MODE_DIV16, 10'h008, 1'b0, 1'b1);
    t_rate(`SPM_MODE_DIV64, 10'h020, 1'b0, 1'b1);
    t_rate(`SPM_MODE_TIMER, 10'h005, 1'b1, 1'b1);
    @(posedge ref_clk);
    addr <= 8'h04;
    t_rate(`SPM_MODE_BRG, 10'h00a, 1'b0, 1'b0);
    t_slave();
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
endmodule
